/* File: pkg/coh_params.svh */
`ifndef COH_PARAMS_SVH
`define COH_PARAMS_SVH
// Notes on behaviour
// R1 - set/way clean, invalidate, clean+invalidate touch only the issuing core
// R2 - clean by address to coherency/unification broadcast only if shareable
// R3 - clean and invalidate by address to coherency is always broadcast
// R4 - force broadcast bit spreads tlb and local icache ops from ns el1
// R5 - icache op with inner domain qualifier reaches every icache in domain
// R6 - core joins coherency only if powered, cache and mmu on, addr coherent
// R7 - icaches never take part in coherency; icache ops never touch tags
// R8 - each data line holds one of modified, owned, exclusive, shared, invalid
// R9 - modified is the sole, newest copy and differs from memory
// R10 - owned is dirty and shareable; one owner, other holders shared
// R11 - exclusive matches memory and no other cache holds the line
// R12 - shared is newest data, may differ from memory, may have other copies
// R13 - write only in modified or exclusive; shared invalidates others first
// R14 - shared may drop to invalid anytime; modified written back first
// R15 - reader of a modified line gets the updated data
// R16 - exclusive holder moves to shared when another cache reads the line
// R17 - shared tracking is imprecise; no upgrade after other holder drops
// R18 - duplicate tags mirror every core's data cache tags
// R19 - all core fetches and data accesses to l2 are arbitrated here
// R20 - clean and dirty lines move cache to cache without memory access
// R21 - caches and this unit exchange requests and responses both ways
// R22 - invalidate-all icache with inner qualifier broadcast within inner only
// R23 - invalidate by address to coherency is always broadcast
// R24 - barrier waits for own broadcasts, never for ones received
// R25 - after reset every duplicate tag entry is invalid
`define NCORES 2
`define CORE_BITS 1
`define ADDR_BITS 16
`define SET_BITS 4
`define SETS 16
`define SET_LSB 4
`define TAG_BITS 8
`define TAG_LSB 8
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define CTRL_RESET 4'h0
`define CTRL_EN_BIT 0
`define CTRL_PART_LSB 1
`define CTRL_FB_BIT 3
`endif

/* File: pkg/coh_pkg.sv */
`include "coh_params.svh"
package coh_pkg;
  typedef logic [`CORE_BITS-1:0] core_id_t;
  typedef logic [`NCORES-1:0] core_mask_t;
  typedef enum logic [2:0] {
    ST_I = 3'b000, ST_S = 3'b001, ST_E = 3'b010, ST_O = 3'b011, ST_M = 3'b100
  } line_st_t;
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_WRITE = 4'h1, OP_EVICT = 4'h2, OP_IFETCH = 4'h3,
    OP_DCACHE_INVAL_SETWAY = 4'h4, OP_DCACHE_CLEAN_SETWAY = 4'h5,
    OP_DCACHE_CLEAN_INVAL_SETWAY = 4'h6,
    OP_DCACHE_CLEAN_ADDR_TO_COHERENCY = 4'h7,
    OP_DCACHE_CLEAN_ADDR_TO_UNIFICATION = 4'h8,
    OP_DCACHE_CLEAN_INVAL_ADDR_TO_COHERENCY = 4'h9,
    OP_DCACHE_INVAL_ADDR_TO_COHERENCY = 4'hA,
    OP_ICACHE_INVAL_ALL_LOCAL = 4'hB, OP_ICACHE_INVAL_ALL_INNER_DOMAIN = 4'hC,
    OP_TLB_INVAL = 4'hD, OP_COMPLETION_BARRIER = 4'hE
  } op_t;
  typedef enum logic [2:0] {
    SNP_NONE = 3'b000, SNP_SHARE = 3'b001, SNP_INVAL = 3'b010,
    SNP_CLEAN = 3'b011, SNP_CLEAN_INVAL = 3'b100, SNP_IC_INVAL = 3'b101,
    SNP_TLB_INVAL = 3'b110
  } snp_kind_t;
  typedef enum logic [2:0] {
    FSM_IDLE = 3'b000, FSM_LOOK = 3'b001, FSM_SNOOP = 3'b010,
    FSM_L2 = 3'b011, FSM_RESP = 3'b100
  } fsm_t;
  typedef struct packed {
    logic valid;
    op_t op;
    logic [`ADDR_BITS-1:0] addr;
    logic shareable;
    logic coherent;
    logic ns_el1;
  } core_req_t;
  typedef struct packed {
    logic ack;
    line_st_t state;
    logic c2c;
  } core_resp_t;
  typedef struct packed {
    logic valid;
    snp_kind_t kind;
    logic [`ADDR_BITS-1:0] addr;
  } snoop_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic ifetch;
    core_id_t core;
    logic [`ADDR_BITS-1:0] addr;
  } l2_req_t;
endpackage

/* File: verif/coh_checker_sva.sv */
`timescale 1ns/1ps
`include "coh_params.svh"
module coh_checker import coh_pkg::*; (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic [`NCORES-1:0] CORE_PWR_I,
  input wire core_req_t [`NCORES-1:0] REQ_I,
  input wire core_resp_t [`NCORES-1:0] RESP_O,
  input wire snoop_t [`NCORES-1:0] SNP_O,
  input wire logic [`NCORES-1:0] SNP_ACK_I,
  input wire l2_req_t L2_O,
  input wire logic L2_ACK_I
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  logic seen_q;
  snp_kind_t kind_q;
  ////////////////////////////////////////////////////////////////////////////
  // core 1 snoop seen since the last answer
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      seen_q <= 1'b0;
      kind_q <= SNP_NONE;
    end else if (RESP_O[0].ack || RESP_O[1].ack) begin
      seen_q <= 1'b0;
    end else if (SNP_O[1].valid && SNP_ACK_I[1]) begin
      seen_q <= 1'b1;
      kind_q <= SNP_O[1].kind;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // core 1 powered past the sync flops
  sequence pwr1_steady;
    CORE_PWR_I[1] && $past(CORE_PWR_I[1], 4);
  endsequence
  sequence l2_waiting;
    L2_O.valid && !L2_ACK_I;
  endsequence
  sequence setway_done0;
    RESP_O[0].ack && REQ_I[0].op inside {OP_DCACHE_INVAL_SETWAY,
      OP_DCACHE_CLEAN_SETWAY, OP_DCACHE_CLEAN_INVAL_SETWAY};
  endsequence
  sequence inval_done0;
    RESP_O[0].ack && REQ_I[0].op inside {OP_DCACHE_INVAL_ADDR_TO_COHERENCY,
      OP_DCACHE_CLEAN_INVAL_ADDR_TO_COHERENCY};
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  resp_pulse_a: assert property (RESP_O[0].ack |-> REQ_I[0].valid
    ##1 !RESP_O[0].ack) else $error("ack not a pulse");
  l2_hold_a: assert property (l2_waiting |=> L2_O.valid &&
    $stable(L2_O.addr) && $stable(L2_O.write)) else $error("l2 request moved");
  l2_release_a: assert property (L2_O.valid && L2_ACK_I |=>
    !L2_O.valid) else $error("l2 kept after ack");
  snoop_hold_a: assert property (SNP_O[1].valid && !SNP_ACK_I[1] |=>
    SNP_O[1].valid && $stable(SNP_O[1].kind)) else $error("snoop moved");
  reset_clear_a: assert property ($rose(RST_B_I) |-> RESP_O == '0 &&
    SNP_O == '0 && L2_O == '0) else $error("busy after reset");
  setway_local_a: assert property (setway_done0 |-> !seen_q)
    else $error("set way op broadcast");
  inval_bcast_a: assert property (inval_done0 and pwr1_steady |->
    seen_q) else $error("inval not broadcast");
  ic_inner_a: assert property (RESP_O[0].ack && REQ_I[0].op ==
    OP_ICACHE_INVAL_ALL_INNER_DOMAIN ##0 pwr1_steady |-> seen_q &&
    kind_q == SNP_IC_INVAL) else $error("inner ic op not broadcast");
  write_state_a: assert property (RESP_O[0].ack &&
    REQ_I[0].op == OP_WRITE |-> !(RESP_O[0].state inside {ST_S, ST_E, ST_O}))
    else $error("write not modified");
  excl_clean_a: assert property (RESP_O[0].ack &&
    RESP_O[0].state == ST_E |-> !RESP_O[0].c2c)
    else $error("exclusive from a cache");
endmodule // coh_checker

bind coherency_control_unit coh_checker chk_u (.CLOCK_I(CLOCK_I),
  .RST_B_I(RST_B_I), .CORE_PWR_I(CORE_PWR_I), .REQ_I(REQ_I),
  .RESP_O(RESP_O), .SNP_O(SNP_O), .SNP_ACK_I(SNP_ACK_I), .L2_O(L2_O),
  .L2_ACK_I(L2_ACK_I));

/* File: verif/coh_far_side.sv */
`timescale 1ns/1ps
`include "coh_params.svh"
module coh_far_side import coh_pkg::*; (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic slow_i,
  input wire snoop_t [`NCORES-1:0] snp_i,
  input wire l2_req_t l2_i,
  output logic [`NCORES-1:0] snp_ack_o,
  output logic l2_ack_o
);
  logic [`NCORES:0][3:0] wait_q;
  logic [`NCORES:0] busy, ack_q;
  ////////////////////////////////////////////////////////////////////////////
  // top slot is l2, the rest are the data caches
  always_comb begin
    for (int i = 0; i < `NCORES; i++) busy[i] = snp_i[i].valid;
    busy[`NCORES] = l2_i.valid;
  end
  // one ack per request, 6 cycles after it appears when slow
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= '0;
      wait_q <= '0;
    end else begin
      for (int i = 0; i <= `NCORES; i++) begin
        ack_q[i] <= busy[i] && !ack_q[i] &&
          wait_q[i] >= (slow_i ? 4'h5 : 4'h0);
        wait_q[i] <= (busy[i] && !ack_q[i]) ? wait_q[i] + 4'h1 : 4'h0;
      end
    end
  end
  assign snp_ack_o = ack_q[`NCORES-1:0];
  assign l2_ack_o = ack_q[`NCORES];
endmodule // coh_far_side

/* File: verif/coherency_control_unit_tb_top.sv */
`timescale 1ns/1ps
`include "coh_params.svh"
module coherency_control_unit_tb_top import coh_pkg::*; ;
  localparam logic [15:0] A = 16'h1230;
  localparam logic [15:0] B = 16'h4560;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwr = 1'b0, slow = 1'b0;
  logic hrdy, hresp, l2_ack, l2_wr, coh = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, pwr = 2'h3, snp_ack;
  core_req_t [1:0] req = '0;
  core_resp_t [1:0] resp;
  snoop_t [1:0] snp;
  l2_req_t l2;
  snp_kind_t kind [2];
  int errors, checks, cyc, ns [2], nl, ds, dl, n;
  // op, shareable, ns el1, snoop seen by core 1
  op_t mt [15] = '{OP_DCACHE_INVAL_SETWAY, OP_DCACHE_CLEAN_SETWAY,
    OP_DCACHE_CLEAN_INVAL_SETWAY, OP_DCACHE_CLEAN_ADDR_TO_COHERENCY,
    OP_DCACHE_CLEAN_ADDR_TO_COHERENCY, OP_DCACHE_CLEAN_ADDR_TO_UNIFICATION,
    OP_DCACHE_CLEAN_ADDR_TO_UNIFICATION,
    OP_DCACHE_CLEAN_INVAL_ADDR_TO_COHERENCY,
    OP_DCACHE_INVAL_ADDR_TO_COHERENCY, OP_ICACHE_INVAL_ALL_INNER_DOMAIN,
    OP_ICACHE_INVAL_ALL_LOCAL, OP_TLB_INVAL, OP_ICACHE_INVAL_ALL_LOCAL,
    OP_TLB_INVAL, OP_TLB_INVAL};
  logic [14:0] msh = 15'h0057, mel = 15'h3C00;
  snp_kind_t mk [15] = '{SNP_NONE, SNP_NONE, SNP_NONE, SNP_NONE, SNP_CLEAN,
    SNP_NONE, SNP_CLEAN, SNP_CLEAN_INVAL, SNP_INVAL, SNP_IC_INVAL, SNP_NONE,
    SNP_NONE, SNP_IC_INVAL, SNP_TLB_INVAL, SNP_NONE};
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 clk = ~clk;
  end
  coherency_control_unit dut (.CLOCK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwr),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .CORE_PWR_I(pwr), .REQ_I(req),
    .RESP_O(resp), .SNP_O(snp), .SNP_ACK_I(snp_ack), .SNP_DIRTY_I(2'h0),
    .L2_O(l2), .L2_ACK_I(l2_ack));
  coh_far_side far (.clock_i(clk), .rst_b_i(rst_b), .slow_i(slow),
    .snp_i(snp), .l2_i(l2), .snp_ack_o(snp_ack), .l2_ack_o(l2_ack));
  // tally snoops and l2 transfers; a hang ends the run
  always @(posedge clk) begin
    cyc++;
    for (int c = 0; c < 2; c++)
      if (snp[c].valid && snp_ack[c]) begin
        ns[c]++;
        kind[c] = snp[c].kind;
      end
    if (l2.valid && l2_ack) begin
      nl++;
      l2_wr = l2.write;
    end
    if (cyc == 5000) begin
      errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(string s, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task chk_st(string s, line_st_t e, line_st_t g);
    chk(s, {29'h0, e}, {29'h0, g});
  endtask
  // hsel stays up between transfers
  task ahb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwr <= w;
    n = 0;
    do @(posedge clk); while (hrdy !== 1'b1 && n++ < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1 && n++ < 40);
    rd = hrdata;
  endtask
  // l below zero skips the l2 count
  task tx(int c, op_t x, logic [15:0] a, logic sh, logic el, line_st_t s,
    logic k, snp_kind_t ek, int l);
    ds = ns[1-c];
    dl = nl;
    @(posedge clk);
    req[c] <= '{1'b1, x, a, sh, coh, el};
    n = 0;
    do @(posedge clk); while (resp[c].ack !== 1'b1 && n++ < 100);
    chk("ack", 32'h1, {31'h0, resp[c].ack});
    if (coh && x inside {OP_READ, OP_WRITE}) chk_st("state", s, resp[c].state);
    if (coh && x == OP_READ) chk("c2c", {31'h0, k}, {31'h0, resp[c].c2c});
    req[c] <= '0;
    chk("snoops", {31'h0, ek != SNP_NONE}, ns[1-c] - ds);
    if (ek != SNP_NONE) chk("kind", {29'h0, ek}, {29'h0, kind[1-c]});
    if (l >= 0) chk("l2", l, nl - dl);
  endtask
  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl", 32'h0, rd);
    ahb(1'b0, 32'h0000_0004, 32'h0);
    chk("status", 32'h0000_00C0, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, 32'h0, 32'h0000_0007);
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl", 32'h0000_0007, rd);
    // slow far side
    slow <= 1'b1;
    tx(0, OP_READ, A, 1, 0, ST_E, 0, SNP_NONE, 1);
    tx(1, OP_READ, A, 1, 0, ST_S, 1, SNP_SHARE, 0);
    tx(1, OP_WRITE, A, 1, 0, ST_M, 0, SNP_INVAL, 0);
    tx(0, OP_READ, A, 1, 0, ST_S, 1, SNP_SHARE, 0);
    tx(1, OP_WRITE, A, 1, 0, ST_M, 0, SNP_INVAL, 0);
    tx(0, OP_WRITE, B, 1, 0, ST_M, 0, SNP_NONE, 1);
    tx(1, OP_READ, B, 1, 0, ST_S, 1, SNP_SHARE, 0);
    tx(0, OP_EVICT, B, 1, 0, ST_I, 0, SNP_NONE, 1);
    chk("l2 write", 32'h1, {31'h0, l2_wr});
    tx(1, OP_EVICT, B, 1, 0, ST_I, 0, SNP_NONE, 0);
    tx(0, OP_READ, B, 1, 0, ST_E, 0, SNP_NONE, 1);
    tx(0, OP_IFETCH, A, 1, 0, ST_I, 0, SNP_NONE, 1);
    coh <= 1'b0;
    tx(0, OP_READ, A, 1, 0, ST_I, 0, SNP_NONE, 1);
    coh <= 1'b1;
    // maintenance table, force broadcast from entry 12
    slow <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      if (i == 12) ahb(1'b1, 32'h0, 32'h0000_000F);
      tx(0, mt[i], A, msh[i], mel[i], ST_I, 0, mk[i], -1);
    end
    // unpowered core gets no broadcast
    pwr <= 2'h1;
    repeat (4) @(posedge clk);
    ahb(1'b0, 32'h0000_0004, 32'h0);
    chk("status", 32'h0000_0040, rd);
    tx(0, OP_ICACHE_INVAL_ALL_INNER_DOMAIN, A, 0, 0, ST_I, 0, SNP_NONE, -1);
    pwr <= 2'h3;
    tx(0, OP_COMPLETION_BARRIER, A, 0, 0, ST_I, 0, SNP_NONE, -1);
    // mid-run reset forgets holders
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl", 32'h0, rd);
    ahb(1'b1, 32'h0, 32'h0000_0007);
    tx(1, OP_READ, B, 1, 0, ST_E, 0, SNP_NONE, 1);
    results();
  end
endmodule // coherency_control_unit_tb_top

/* File: verilog/coherency_control_unit.sv */
`timescale 1ns/1ps
`include "coh_params.svh"
module coherency_control_unit import coh_pkg::*; (
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic [`NCORES-1:0] CORE_PWR_I,
  input wire core_req_t [`NCORES-1:0] REQ_I,
  output core_resp_t [`NCORES-1:0] RESP_O,
  output snoop_t [`NCORES-1:0] SNP_O,
  input wire logic [`NCORES-1:0] SNP_ACK_I,
  input wire logic [`NCORES-1:0] SNP_DIRTY_I,
  output l2_req_t L2_O,
  input wire logic L2_ACK_I
);

  ////////////////////////////////////////////////////////////////////////////
  // power pins come from another domain
  logic [`NCORES-1:0] pwr_meta_q;
  logic [`NCORES-1:0] pwr_q;

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pwr_meta_q <= '0;
      pwr_q <= '0;
    end else if (CE_I) begin
      pwr_meta_q <= CORE_PWR_I;
      pwr_q <= pwr_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave, zero wait states
  logic [3:0] ctrl_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic [31:0] rd_mux;
  logic [3:0] ctrl_now;
  logic [31:0] status;
  fsm_t state_q;
  core_mask_t pend_q;

  // forward a pending write so a read right behind it is fresh
  always_comb begin
    ctrl_now = ctrl_q;
    if (wr_pend_q && wr_addr_q == `REG_CTRL) begin
      ctrl_now = HWDATA_I[3:0];
    end
  end

  assign status = {24'h0000_00, pwr_q, pend_q, 1'b0, state_q};

  // unmapped: read zero, writes ignored
  always_comb begin
    if (HADDR_I == `REG_CTRL) begin
      rd_mux = {28'h000_0000, ctrl_now};
    end else if (HADDR_I == `REG_STATUS) begin
      rd_mux = status;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // address phase; read data loaded ahead of data phase
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      hrdata_q <= 32'h0000_0000;
    end else if (CE_I && HREADY_I) begin
      wr_pend_q <= HSEL_I && HTRANS_I[1] && HWRITE_I;
      wr_addr_q <= HADDR_I;
      if (HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ctrl_q <= `CTRL_RESET;
    end else if (CE_I && wr_pend_q && wr_addr_q == `REG_CTRL) begin
      ctrl_q <= HWDATA_I[3:0];
    end
  end

  // never stalls and always answers okay
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      hready_q <= 1'b1;
    end else if (CE_I) begin
      hready_q <= 1'b1;
    end
  end

  assign HRDATA_O = hrdata_q;
  assign HREADYOUT_O = hready_q;
  assign HRESP_O = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // duplicate tags of every core's data cache
  line_st_t dst_q [`NCORES][`SETS];
  logic [`TAG_BITS-1:0] dtg_q [`NCORES][`SETS];
  core_id_t cur_q;
  core_id_t rr_q;
  core_req_t req_q;
  logic [`SET_BITS-1:0] set;
  logic [`TAG_BITS-1:0] tag;
  core_mask_t hit;
  core_mask_t part;
  core_mask_t oth;
  line_st_t cur_st;

  assign set = req_q.addr[`SET_LSB +: `SET_BITS];
  assign tag = req_q.addr[`TAG_LSB +: `TAG_BITS];
  assign cur_st = dst_q[cur_q][set];

  // coherent only powered, cache and mmu on
  always_comb begin
    for (int c = 0; c < `NCORES; c++) begin
      part[c] = ctrl_q[`CTRL_EN_BIT] && ctrl_q[`CTRL_PART_LSB + c] &&
        pwr_q[c]; // [R6]
      hit[c] = (dst_q[c][set] != ST_I) && (dtg_q[c][set] == tag); // [R18]
      oth[c] = hit[c] && part[c] && (core_id_t'(c) != cur_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decision for the captured request
  snp_kind_t dec_kind;
  core_mask_t dec_mask;
  logic dec_l2;
  logic dec_l2wr;
  logic dec_upd;
  logic dec_swy;
  line_st_t dec_nst;
  core_mask_t self_m;
  core_mask_t all_m;
  logic fb;
  logic coh;

  assign self_m = core_mask_t'(1) << cur_q;
  assign all_m = pwr_q | self_m;
  assign fb = ctrl_q[`CTRL_FB_BIT] && req_q.ns_el1;
  assign coh = part[cur_q] && req_q.coherent; // [R6]

  always_comb begin
    dec_kind = SNP_NONE;
    dec_mask = '0;
    dec_l2 = 1'b0;
    dec_l2wr = 1'b0;
    dec_upd = 1'b0;
    dec_swy = 1'b0;
    dec_nst = ST_I;
    case (req_q.op)
      OP_READ: begin
        if (!coh) begin
          dec_l2 = 1'b1;
        end else if (!hit[cur_q]) begin
          dec_upd = 1'b1;
          if (|oth) begin
            // holders share it: m to o, e to s; reader gets s
            dec_kind = SNP_SHARE; // [R15] [R16] [R20] [R10]
            dec_mask = oth;
            dec_nst = ST_S; // [R12]
          end else begin
            dec_l2 = 1'b1;
            dec_nst = ST_E; // [R11]
          end
        end
      end
      OP_WRITE: begin
        if (!coh) begin
          dec_l2 = 1'b1;
          dec_l2wr = 1'b1;
        end else begin
          dec_upd = 1'b1;
          dec_nst = ST_M; // [R13] [R9]
          if (!(hit[cur_q] && (cur_st == ST_M || cur_st == ST_E))) begin
            dec_kind = SNP_INVAL; // [R13] [R20]
            dec_mask = oth;
            dec_l2 = !hit[cur_q] && !(|oth);
          end
        end
      end
      OP_EVICT: begin
        if (hit[cur_q]) begin
          // dirty lines go back to l2 first, clean ones just drop
          dec_upd = 1'b1;
          dec_nst = ST_I; // [R14] [R17]
          dec_l2 = (cur_st == ST_M) || (cur_st == ST_O); // [R14]
          dec_l2wr = dec_l2;
        end
      end
      OP_IFETCH: begin
        dec_l2 = 1'b1; // [R19] [R7]
      end
      OP_DCACHE_INVAL_SETWAY: begin
        dec_kind = SNP_INVAL;
        dec_mask = self_m; // [R1]
        dec_swy = 1'b1;
      end
      OP_DCACHE_CLEAN_SETWAY: begin
        dec_kind = SNP_CLEAN;
        dec_mask = self_m; // [R1]
        dec_swy = 1'b1;
      end
      OP_DCACHE_CLEAN_INVAL_SETWAY: begin
        dec_kind = SNP_CLEAN_INVAL;
        dec_mask = self_m; // [R1]
        dec_swy = 1'b1;
      end
      OP_DCACHE_CLEAN_ADDR_TO_COHERENCY,
      OP_DCACHE_CLEAN_ADDR_TO_UNIFICATION: begin
        dec_kind = SNP_CLEAN;
        dec_mask = req_q.shareable ? all_m : self_m; // [R2]
      end
      OP_DCACHE_CLEAN_INVAL_ADDR_TO_COHERENCY: begin
        dec_kind = SNP_CLEAN_INVAL;
        dec_mask = all_m; // [R3]
      end
      OP_DCACHE_INVAL_ADDR_TO_COHERENCY: begin
        dec_kind = SNP_INVAL;
        dec_mask = all_m; // [R23]
      end
      OP_ICACHE_INVAL_ALL_LOCAL: begin
        dec_kind = SNP_IC_INVAL;
        dec_mask = fb ? all_m : self_m; // [R4]
      end
      OP_ICACHE_INVAL_ALL_INNER_DOMAIN: begin
        // the whole cluster is the inner domain; nothing leaves it
        dec_kind = SNP_IC_INVAL;
        dec_mask = all_m; // [R5] [R22]
      end
      OP_TLB_INVAL: begin
        dec_kind = SNP_TLB_INVAL;
        dec_mask = fb ? all_m : self_m; // [R4]
      end
      default: begin
        dec_kind = SNP_NONE;
      end
    endcase
  end

  // what a snoop leaves behind in a holder's tag
  function automatic line_st_t snp_effect(snp_kind_t k, line_st_t s);
    line_st_t r;
    r = s;
    case (k)
      SNP_SHARE: begin
        if (s == ST_M) begin
          r = ST_O; // [R10]
        end else if (s == ST_E) begin
          r = ST_S; // [R16]
        end
      end
      SNP_INVAL, SNP_CLEAN_INVAL: begin
        r = ST_I;
      end
      SNP_CLEAN: begin
        if (s == ST_M) begin
          r = ST_E;
        end else if (s == ST_O) begin
          r = ST_S;
        end
      end
      default: begin
        r = s; // [R7]
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // one request at a time, round robin over cores
  snp_kind_t kind_q;
  core_mask_t mask_q;
  core_mask_t acked_q;
  logic l2_q;
  logic l2wr_q;
  logic upd_q;
  logic swy_q;
  logic c2c_q;
  line_st_t nst_q;
  logic any_req;
  core_id_t grant;
  core_mask_t acked_now;

  // rotation assumes a power-of-two core count
  always_comb begin
    any_req = 1'b0;
    grant = rr_q;
    for (int i = `NCORES - 1; i >= 0; i--) begin
      if (REQ_I[rr_q + core_id_t'(i)].valid) begin
        any_req = 1'b1;
        grant = rr_q + core_id_t'(i);
      end
    end
  end

  assign acked_now = acked_q | (SNP_ACK_I & mask_q);

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_q <= FSM_IDLE;
      cur_q <= '0;
      rr_q <= '0;
      req_q <= '0;
      kind_q <= SNP_NONE;
      mask_q <= '0;
      acked_q <= '0;
      l2_q <= 1'b0;
      l2wr_q <= 1'b0;
      upd_q <= 1'b0;
      swy_q <= 1'b0;
      c2c_q <= 1'b0;
      nst_q <= ST_I;
    end else if (CE_I) begin
      case (state_q)
        FSM_IDLE: begin
          if (any_req) begin
            cur_q <= grant; // [R19]
            rr_q <= grant + core_id_t'(1);
            req_q <= REQ_I[grant]; // [R21]
            state_q <= FSM_LOOK;
          end
        end
        FSM_LOOK: begin
          kind_q <= dec_kind;
          mask_q <= dec_mask;
          acked_q <= '0;
          l2_q <= dec_l2;
          l2wr_q <= dec_l2wr;
          upd_q <= dec_upd;
          swy_q <= dec_swy;
          nst_q <= dec_nst;
          c2c_q <= 1'b0;
          if (req_q.op == OP_COMPLETION_BARRIER) begin
            if (!pend_q[cur_q]) begin
              state_q <= FSM_RESP; // [R24]
            end
          end else if (|dec_mask) begin
            state_q <= FSM_SNOOP;
          end else if (dec_l2) begin
            state_q <= FSM_L2;
          end else begin
            state_q <= FSM_RESP;
          end
        end
        FSM_SNOOP: begin
          acked_q <= acked_now;
          if (|(SNP_ACK_I & mask_q & ~self_m)) begin
            c2c_q <= 1'b1; // [R20]
          end
          if (acked_now == mask_q) begin
            state_q <= l2_q ? FSM_L2 : FSM_RESP;
          end
        end
        FSM_L2: begin
          if (L2_ACK_I) begin
            state_q <= FSM_RESP;
          end
        end
        FSM_RESP: begin
          state_q <= FSM_IDLE;
        end
        default: begin
          state_q <= FSM_IDLE;
        end
      endcase
    end
  end

  // issuer's broadcast in flight; received snoops never set it
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      pend_q <= '0;
    end else if (CE_I) begin
      if (state_q == FSM_LOOK && |(dec_mask & ~self_m)) begin
        pend_q[cur_q] <= 1'b1; // [R24]
      end else if (state_q == FSM_SNOOP && acked_now == mask_q) begin
        pend_q[cur_q] <= 1'b0;
      end
    end
  end

  // tags change only when the request completes
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int c = 0; c < `NCORES; c++) begin
        for (int s = 0; s < `SETS; s++) begin
          dst_q[c][s] <= ST_I; // [R25] [R8]
          dtg_q[c][s] <= '0;
        end
      end
    end else if (CE_I && state_q == FSM_RESP) begin
      for (int c = 0; c < `NCORES; c++) begin
        if (mask_q[c] && (swy_q || hit[c])) begin
          dst_q[c][set] <= snp_effect(kind_q, dst_q[c][set]); // [R8]
        end
      end
      if (upd_q) begin
        dst_q[cur_q][set] <= nst_q; // [R18]
        dtg_q[cur_q][set] <= tag;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the caches and l2
  core_resp_t [`NCORES-1:0] resp_q;
  snoop_t [`NCORES-1:0] snp_q;
  l2_req_t l2o_q;

  // ack is a one-cycle pulse
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      resp_q <= '0;
    end else if (CE_I) begin
      resp_q <= '0;
      if (state_q != FSM_RESP && state_q != FSM_IDLE) begin
        if ((state_q == FSM_LOOK && req_q.op == OP_COMPLETION_BARRIER &&
            !pend_q[cur_q]) ||
            (state_q == FSM_LOOK && req_q.op != OP_COMPLETION_BARRIER &&
            !(|dec_mask) && !dec_l2) ||
            (state_q == FSM_SNOOP && acked_now == mask_q && !l2_q) ||
            (state_q == FSM_L2 && L2_ACK_I)) begin
          resp_q[cur_q].ack <= 1'b1; // [R21]
          resp_q[cur_q].state <= (state_q == FSM_LOOK) ? dec_nst : nst_q;
          resp_q[cur_q].c2c <= c2c_q ||
            (state_q == FSM_SNOOP && |(SNP_ACK_I & mask_q & ~self_m));
        end
      end
    end
  end

  // a snoop stands until its ack
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      snp_q <= '0;
    end else if (CE_I) begin
      for (int c = 0; c < `NCORES; c++) begin
        if (state_q == FSM_LOOK && dec_mask[c] &&
            req_q.op != OP_COMPLETION_BARRIER) begin
          snp_q[c].valid <= 1'b1; // [R21]
          snp_q[c].kind <= dec_kind;
          snp_q[c].addr <= req_q.addr;
        end else if (SNP_ACK_I[c]) begin
          snp_q[c].valid <= 1'b0;
        end
      end
    end
  end

  // l2 request stands until its ack
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      l2o_q <= '0;
    end else if (CE_I) begin
      if (l2o_q.valid && L2_ACK_I) begin
        l2o_q.valid <= 1'b0;
      end else if ((state_q == FSM_LOOK && !(|dec_mask) && dec_l2 &&
                   req_q.op != OP_COMPLETION_BARRIER) ||
                   (state_q == FSM_SNOOP && acked_now == mask_q && l2_q)) begin
        l2o_q.valid <= 1'b1; // [R19]
        l2o_q.write <= (state_q == FSM_LOOK) ? dec_l2wr : l2wr_q;
        l2o_q.ifetch <= req_q.op == OP_IFETCH;
        l2o_q.core <= cur_q;
        l2o_q.addr <= req_q.addr;
      end
    end
  end

  assign RESP_O = resp_q;
  assign SNP_O = snp_q;
  assign L2_O = l2o_q;

endmodule // coherency_control_unit
